// [bbp_periph.sv]
// Peripheral model facing one channel's eight parallel lines
`timescale 1ns/100ps
`default_nettype none
module bbp_periph (
	input wire logic [7:0] port_out,
	input wire logic [7:0] port_oe,
	input wire logic [7:0] ext_val,
	output logic [7:0] port_in
);
	// Lines the port drives read back its value, the rest show the peripheral's
	assign port_in = (port_out & port_oe) | (ext_val & ~port_oe);
endmodule
`default_nettype wire

// [bbp_port.sv]
// Two-channel bit-bang parallel port with strobes and flush/wake pins

`timescale 1ns/100ps
`default_nettype none

module bbp_port
	import bbp_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	// Channel configuration from the USB side
	input wire logic [1:0] bb_enable,
	input wire logic [1:0] bb_sync,
	input wire logic [7:0] dir_mask_a,
	input wire logic [7:0] dir_mask_b,
	// Host write stream
	input wire logic [1:0] host_wr_valid,
	output logic [1:0] host_wr_ready,
	input wire logic [7:0] host_wr_data_a,
	input wire logic [7:0] host_wr_data_b,
	// Host read stream
	input wire logic [1:0] host_rd_req,
	output logic [1:0] host_rd_valid,
	input wire logic [1:0] host_rd_ready,
	output logic [7:0] host_rd_data_a,
	output logic [7:0] host_rd_data_b,
	// Suspend and wakeup state
	input wire logic usb_suspended,
	input wire logic remote_wake_en,
	output logic resume_req,
	output logic [1:0] send_immediate,
	// Pins
	input wire logic [7:0] chan_a_port_in,
	output logic [7:0] chan_a_port_out,
	output logic [7:0] chan_a_port_oe,
	input wire logic [7:0] chan_b_port_in,
	output logic [7:0] chan_b_port_out,
	output logic [7:0] chan_b_port_oe,
	output logic write_strobe_n_a,
	output logic write_strobe_n_b,
	output logic read_strobe_n_a,
	output logic read_strobe_n_b,
	input wire logic flush_or_wake_n_a,
	input wire logic flush_or_wake_n_b,
	output logic power_enable_n
);
	// Per-channel views of the separate ports
	logic [7:0] pin_raw [BBP_CHANNELS];
	logic [7:0] pin_level [BBP_CHANNELS];
	logic [7:0] wr_data [BBP_CHANNELS];
	logic [7:0] dir_mask [BBP_CHANNELS];
	logic [7:0] port_out [BBP_CHANNELS];
	logic [7:0] port_oe [BBP_CHANNELS];
	logic [7:0] rd_data [BBP_CHANNELS];
	logic [1:0] wr_strobe_n;
	logic [1:0] rd_strobe_n;
	logic [1:0] flush_level;
	logic [1:0] flush_prev;
	logic [1:0] resume_hit;

	assign pin_raw[0] = chan_a_port_in;
	assign pin_raw[1] = chan_b_port_in;
	assign wr_data[0] = host_wr_data_a;
	assign wr_data[1] = host_wr_data_b;
	assign dir_mask[0] = dir_mask_a;
	assign dir_mask[1] = dir_mask_b;
	assign chan_a_port_out = port_out[0];
	assign chan_b_port_out = port_out[1];
	assign chan_a_port_oe = port_oe[0];
	assign chan_b_port_oe = port_oe[1];
	assign host_rd_data_a = rd_data[0];
	assign host_rd_data_b = rd_data[1];
	assign write_strobe_n_a = wr_strobe_n[0];
	assign write_strobe_n_b = wr_strobe_n[1];
	assign read_strobe_n_a = rd_strobe_n[0];
	assign read_strobe_n_b = rd_strobe_n[1];

	// Flush/wake pins idle high, so the synchroniser resets high
	bbp_sync #(
		.W(2),
		.RST_VAL(BBP_PIN_IDLE[1:0])
	) u_flush_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.pin({flush_or_wake_n_b, flush_or_wake_n_a}),
		.level(flush_level)
	);

	// Suspend indication mirrors the USB state, high while suspended
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			power_enable_n <= 1'b0;
			flush_prev <= BBP_PIN_IDLE[1:0];
		end else begin
			power_enable_n <= usb_suspended;
			flush_prev <= flush_level;
		end
	end

	// Falling edge of the filtered flush/wake level is one strobe
	wire [1:0] flush_fall = flush_prev & ~flush_level;
	wire [1:0] flush_en = flush_fall & bb_enable;
	wire wake_ok = power_enable_n & remote_wake_en;
	wire [1:0] next_send = power_enable_n ? 2'b00 : flush_en;
	assign resume_hit = wake_ok ? flush_en : 2'b00;

	// Both request outputs are single-cycle pulses from flops
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			resume_req <= 1'b0;
			send_immediate <= 2'b00;
		end else begin
			resume_req <= |resume_hit;
			send_immediate <= next_send;
		end
	end

	// One engine per channel, each with its own mode bits
	for (genvar c = 0; c < BBP_CHANNELS; c++) begin : g_chan
		bbp_state_t state;
		bbp_state_t next_state;
		logic [1:0] cnt;
		logic wr_pending;
		logic [7:0] pending_data;
		logic out_valid;

		bbp_sync #(
			.W(BBP_WIDTH),
			.RST_VAL(BBP_PORT_RST)
		) u_pin_sync (
			.clk(clk),
			.sys_rst(sys_rst),
			.pin(pin_raw[c]),
			.level(pin_level[c])
		);

		wire en = bb_enable[c];
		wire sync_mode = bb_sync[c];
		wire idle = (state == BBP_ST_IDLE);
		wire cnt_done = (cnt == 2'd0);
		// A synchronous write needs room for the byte it returns
		wire wr_go = en & idle & host_wr_valid[c] & ~(sync_mode & out_valid);
		wire rd_go = en & idle & ~host_wr_valid[c] & host_rd_req[c] & ~out_valid;
		wire start_sample = (wr_go & sync_mode) | rd_go;
		wire start_write = wr_go & ~sync_mode;
		wire sample_end = (state == BBP_ST_SAMPLE) & cnt_done;
		wire write_end = (state == BBP_ST_WRITE) & cnt_done;
		wire load_port = start_write | (sample_end & wr_pending);

		assign host_wr_ready[c] = wr_go;
		assign host_rd_valid[c] = out_valid;

		// Next state selection
		always_comb begin
			next_state = state;
			unique case (state)
				BBP_ST_IDLE: begin
					if (start_sample) begin
						next_state = BBP_ST_SAMPLE;
					end else if (start_write) begin
						next_state = BBP_ST_WRITE;
					end
				end
				BBP_ST_SAMPLE: begin
					if (cnt_done) begin
						next_state = wr_pending ? BBP_ST_WRITE : BBP_ST_IDLE;
					end
				end
				BBP_ST_WRITE: begin
					if (cnt_done) begin
						next_state = BBP_ST_IDLE;
					end
				end
				default: next_state = BBP_ST_IDLE;
			endcase
			if (!en) begin
				next_state = BBP_ST_IDLE;
			end
		end

		// State, strobe width counter and the held write byte
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				state <= BBP_ST_IDLE;
				cnt <= 2'd0;
				wr_pending <= 1'b0;
				pending_data <= BBP_PORT_RST;
			end else begin
				state <= next_state;
				if (start_sample | load_port) begin
					cnt <= BBP_STROBE_CYC - 2'd1;
				end else if (!cnt_done) begin
					cnt <= cnt - 2'd1;
				end
				if (wr_go) begin
					wr_pending <= sync_mode;
					pending_data <= wr_data[c];
				end else if (sample_end | !en) begin
					wr_pending <= 1'b0;
				end
			end
		end

		// Pin drive: data and enables come straight from flops
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				port_out[c] <= BBP_PORT_RST;
				port_oe[c] <= 8'h00;
			end else begin
				port_oe[c] <= en ? dir_mask[c] : 8'h00;
				if (start_write) begin
					port_out[c] <= wr_data[c];
				end else if (sample_end & wr_pending) begin
					port_out[c] <= pending_data;
				end
			end
		end

		// Write strobe low for the strobe width, falling on the same edge that loads the byte
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				wr_strobe_n[c] <= 1'b1;
			end else if (load_port) begin
				wr_strobe_n[c] <= 1'b0;
			end else if (write_end | !en) begin
				wr_strobe_n[c] <= 1'b1;
			end
		end

		// Read strobe low while sampling; its fall takes the byte, its rise forwards it
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				rd_strobe_n[c] <= 1'b1;
				rd_data[c] <= BBP_PORT_RST;
				out_valid <= 1'b0;
			end else begin
				if (start_sample) begin
					rd_strobe_n[c] <= 1'b0;
					rd_data[c] <= pin_level[c];
				end else if (sample_end | !en) begin
					rd_strobe_n[c] <= 1'b1;
				end
				// New byte wins over a same-cycle take by the host
				if (sample_end) begin
					out_valid <= 1'b1;
				end else if (host_rd_ready[c] | !en) begin
					out_valid <= 1'b0;
				end
			end
		end
	end
endmodule

`default_nettype wire

// [bbp_port_assertions.sv]
// Port-level assertions for the bit-bang port, channel A and shared pins
`timescale 1ns/100ps
`default_nettype none
module bbp_port_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [1:0] bb_enable,
	input wire logic [1:0] bb_sync,
	input wire logic [7:0] dir_mask_a,
	input wire logic [1:0] host_wr_ready,
	input wire logic [7:0] host_wr_data_a,
	input wire logic [1:0] host_rd_valid,
	input wire logic [1:0] host_rd_ready,
	input wire logic [7:0] host_rd_data_a,
	input wire logic usb_suspended,
	input wire logic remote_wake_en,
	input wire logic resume_req,
	input wire logic [1:0] send_immediate,
	input wire logic [7:0] chan_a_port_out,
	input wire logic [7:0] chan_a_port_oe,
	input wire logic write_strobe_n_a,
	input wire logic read_strobe_n_a,
	input wire logic power_enable_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Strobe timing assumes the channel stays enabled through the transfer
	async_write_a: assert property (host_wr_ready[0] && !bb_sync[0] |=>
		!write_strobe_n_a && chan_a_port_out == $past(host_wr_data_a)) else $error("bad write");
	strobe_width_a: assert property (host_wr_ready[0] && !bb_sync[0] |=>
		!write_strobe_n_a [*2] ##1 write_strobe_n_a) else $error("bad strobe width");
	sync_order_a: assert property (host_wr_ready[0] && bb_sync[0] |=> !read_strobe_n_a [*2]
		##1 (read_strobe_n_a && host_rd_valid[0] && !write_strobe_n_a)) else $error("bad order");
	read_hold_a: assert property (host_rd_valid[0] && !host_rd_ready[0] |=>
		host_rd_valid[0] && $stable(host_rd_data_a)) else $error("read byte lost");
	power_copy_a: assert property (1'b1 |=> power_enable_n == $past(usb_suspended))
		else $error("power enable wrong");
	resume_cause_a: assert property (resume_req |->
		$past(power_enable_n) && $past(remote_wake_en)) else $error("stray resume");
	flush_cause_a: assert property (send_immediate[0] |-> !$past(power_enable_n))
		else $error("stray flush");
	oe_follow_a: assert property (1'b1 |=> chan_a_port_oe ==
		($past(bb_enable[0]) ? $past(dir_mask_a) : 8'h00)) else $error("bad enable");
	// Main scenarios seen
	cover property (host_wr_ready[0] && bb_sync[0]);
	cover property (resume_req);
	cover property (send_immediate[0]);
endmodule
bind bbp_port bbp_port_checker u_chk (.clk(clk), .sys_rst(sys_rst), .bb_enable(bb_enable),
	.bb_sync(bb_sync), .dir_mask_a(dir_mask_a), .host_wr_ready(host_wr_ready),
	.host_wr_data_a(host_wr_data_a), .host_rd_valid(host_rd_valid),
	.host_rd_ready(host_rd_ready), .host_rd_data_a(host_rd_data_a),
	.usb_suspended(usb_suspended), .remote_wake_en(remote_wake_en), .resume_req(resume_req),
	.send_immediate(send_immediate), .chan_a_port_out(chan_a_port_out),
	.chan_a_port_oe(chan_a_port_oe), .write_strobe_n_a(write_strobe_n_a),
	.read_strobe_n_a(read_strobe_n_a), .power_enable_n(power_enable_n));
`default_nettype wire

// [bbp_port_bench.sv]
// Self-checking bench for the bit-bang port with peripheral models
`timescale 1ns/100ps
`default_nettype none
module bbp_port_bench;
	logic clk, sys_rst, usb_suspended, remote_wake_en, resume_req, power_enable_n;
	logic [1:0] bb_enable, bb_sync, host_wr_valid, host_wr_ready, host_rd_req;
	logic [1:0] host_rd_valid, host_rd_ready, send_immediate;
	logic [7:0] dir_mask_a, dir_mask_b, host_wr_data_a, host_wr_data_b, host_rd_data_a;
	logic [7:0] host_rd_data_b, chan_a_port_in, chan_a_port_out, chan_a_port_oe;
	logic [7:0] chan_b_port_in, chan_b_port_out, chan_b_port_oe, ext_a, ext_b, d, got, last_a;
	logic write_strobe_n_a, write_strobe_n_b, read_strobe_n_a, read_strobe_n_b;
	logic flush_or_wake_n_a, flush_or_wake_n_b;
	int err_total, cmp_count, seed, hits, wakes;
	logic [7:0] exp_q[$];
	bbp_port dut (.clk, .sys_rst, .bb_enable, .bb_sync, .dir_mask_a, .dir_mask_b,
		.host_wr_valid, .host_wr_ready, .host_wr_data_a, .host_wr_data_b, .host_rd_req,
		.host_rd_valid, .host_rd_ready, .host_rd_data_a, .host_rd_data_b, .usb_suspended,
		.remote_wake_en, .resume_req, .send_immediate, .chan_a_port_in, .chan_a_port_out,
		.chan_a_port_oe, .chan_b_port_in, .chan_b_port_out, .chan_b_port_oe, .write_strobe_n_a,
		.write_strobe_n_b, .read_strobe_n_a, .read_strobe_n_b, .flush_or_wake_n_a,
		.flush_or_wake_n_b, .power_enable_n);
	bbp_periph per_a (.port_out(chan_a_port_out), .port_oe(chan_a_port_oe), .ext_val(ext_a),
		.port_in(chan_a_port_in));
	bbp_periph per_b (.port_out(chan_b_port_out), .port_oe(chan_b_port_oe), .ext_val(ext_b),
		.port_in(chan_b_port_in));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("Compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// One bounded wait step; running out ends the run as a mismatch
	task automatic tick(inout int n);
		@(negedge clk);
		n++;
		if (n > 20) begin
			err_total++;
			final_report();
		end
	endtask
	task automatic wr(input int c, input logic [7:0] v);
		int n;
		n = 0;
		host_wr_data_a = v;
		host_wr_data_b = v;
		host_wr_valid[c] = 1'b1;
		// Let the combinational ready settle before looking at it
		#1;
		while (host_wr_ready[c] !== 1'b1) begin
			tick(n);
			#1;
		end
		@(negedge clk);
		host_wr_valid[c] = 1'b0;
	endtask
	task automatic take_rd(input int c, output logic [7:0] v);
		int n;
		n = 0;
		while (host_rd_valid[c] !== 1'b1) tick(n);
		v = c ? host_rd_data_b : host_rd_data_a;
		host_rd_req[c] = 1'b0;
		host_rd_ready[c] = 1'b1;
		@(negedge clk);
		host_rd_ready[c] = 1'b0;
	endtask
	// Low strobe of four cycles, then count pulses for a while
	task automatic pulse(input int c);
		hits = 0;
		wakes = 0;
		for (int i = 0; i < 16; i++) begin
			if (c == 0) flush_or_wake_n_a = (i >= 4);
			else flush_or_wake_n_b = (i >= 4);
			@(negedge clk);
			hits += int'(send_immediate[c]);
			wakes += int'(resume_req);
		end
	endtask
	initial begin
		seed = 32'h7d55;
		{sys_rst, usb_suspended, remote_wake_en} = 3'b100;
		{bb_enable, bb_sync, host_wr_valid, host_rd_req, host_rd_ready} = '0;
		{dir_mask_a, dir_mask_b} = 16'hffff;
		{host_wr_data_a, host_wr_data_b, ext_a, ext_b, last_a} = '0;
		{flush_or_wake_n_a, flush_or_wake_n_b} = 2'b11;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		bb_enable = 2'b11;
		// Asynchronous writes alternating channels, each strobe checked before the next write
		for (int i = 0; i < 6; i++) begin
			d = 8'($random(seed));
			wr(i % 2, d);
			check(8'((i % 2) ? write_strobe_n_b : write_strobe_n_a), 8'h00);
			repeat (3) @(negedge clk);
			check((i % 2) ? chan_b_port_out : chan_a_port_out, d);
			check(8'((i % 2) ? write_strobe_n_b : write_strobe_n_a), 8'h01);
			if (i % 2 == 0) last_a = d;
		end
		// Synchronous channel A with the high nibble left to the peripheral
		bb_sync = 2'b01;
		dir_mask_a = 8'h0f;
		for (int i = 0; i < 3; i++) begin
			ext_a = 8'($random(seed));
			d = 8'($random(seed));
			repeat (6) @(negedge clk);
			exp_q.push_back({ext_a[7:4], last_a[3:0]});
			wr(0, d);
			take_rd(0, got);
			check(got, exp_q.pop_front());
			check(chan_a_port_out, d);
			last_a = d;
		end
		// Plain read on channel B with every line released
		dir_mask_b = 8'h00;
		ext_b = 8'($random(seed));
		exp_q.push_back(ext_b);
		repeat (6) @(negedge clk);
		check(chan_b_port_oe, 8'h00);
		check(chan_a_port_oe, 8'h0f);
		host_rd_req[1] = 1'b1;
		@(negedge clk);
		check(8'(read_strobe_n_b), 8'h00);
		take_rd(1, got);
		check(got, exp_q.pop_front());
		check(8'(read_strobe_n_b), 8'h01);
		pulse(0);
		check(8'(hits), 8'h01);
		usb_suspended = 1'b1;
		remote_wake_en = 1'b1;
		repeat (3) @(negedge clk);
		check(8'(power_enable_n), 8'h01);
		pulse(1);
		check(8'(wakes), 8'h01);
		remote_wake_en = 1'b0;
		pulse(1);
		check(8'(wakes + hits), 8'h00);
		final_report();
	end
endmodule
`default_nettype wire

// [bbp_sync.sv]
// Package of shared constants and the three-stage pin input synchroniser
package bbp_pkg;
	localparam int BBP_WIDTH = 8;
	localparam int BBP_CHANNELS = 2;
	localparam int BBP_CLK_PERIOD_NS = 100;
	localparam int BBP_STROBE_NS = 200;
	localparam logic [1:0] BBP_STROBE_CYC =
		2'((BBP_STROBE_NS + BBP_CLK_PERIOD_NS - 1) / BBP_CLK_PERIOD_NS);
	localparam logic [7:0] BBP_PORT_RST = 8'h00;
	localparam logic [7:0] BBP_PIN_IDLE = 8'hff;
	typedef enum logic [2:0] {
		BBP_ST_IDLE = 3'b001,
		BBP_ST_SAMPLE = 3'b010,
		BBP_ST_WRITE = 3'b100
	} bbp_state_t;
endpackage

`timescale 1ns/100ps
`default_nettype none

module bbp_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] ff1;
	logic [W-1:0] ff2;
	logic [W-1:0] ff3;
	wire [W-1:0] agree = ~(ff2 ^ ff3);
	wire [W-1:0] next_level = (agree & ff3) | (~agree & level);

	// Three stages; a bit moves only once stages two and three agree
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ff1 <= RST_VAL;
			ff2 <= RST_VAL;
			ff3 <= RST_VAL;
			level <= RST_VAL;
		end else begin
			ff1 <= pin;
			ff2 <= ff1;
			ff3 <= ff2;
			level <= next_level;
		end
	end
endmodule

`default_nettype wire
